// ==== src/loop_lock_pkg.sv ====
package loop_lock_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PHASE_OFFSET = 8'h00;
  localparam logic [7:0] OFS_PHASE_THR    = 8'h04;
  localparam logic [7:0] OFS_FREQ_THR     = 8'h08;
  localparam logic [7:0] OFS_PHASE_WDOG   = 8'h0c;
  localparam logic [7:0] OFS_FREQ_WDOG    = 8'h10;
  localparam logic [7:0] OFS_REF_CTRL     = 8'h14;
  localparam logic [7:0] OFS_WDOG_PER_A   = 8'h18;
  localparam logic [7:0] OFS_WDOG_PER_B   = 8'h1c;
  localparam logic [7:0] OFS_STATUS       = 8'h20;
  localparam logic [7:0] OFS_IRQ_REQ      = 8'h24;

  // ==========================================================
  // Field positions
  localparam int LOCK_EXP_LSB   = 0;
  localparam int UNLOCK_EXP_LSB = 8;
  localparam int CTL_EN_A       = 0;
  localparam int CTL_EN_B       = 1;
  localparam int CTL_ROUTE_A    = 2;
  localparam int CTL_ROUTE_B    = 3;
  localparam int CTL_PIN_A_LSB  = 4;
  localparam int CTL_PIN_B_LSB  = 6;
  localparam int ST_PHASE_LOCK  = 0;
  localparam int ST_FREQ_LOCK   = 1;
  localparam int ST_LOSS_A      = 2;
  localparam int ST_LOSS_B      = 3;
  localparam logic [4:0] LOCK_EXP_MAX = 5'd20;

  // ==========================================================
  // Values after reset
  localparam logic [13:0] RST_OFFSET   = 14'h0000;
  localparam logic [31:0] RST_THR      = 32'h0000_0000;
  localparam logic [7:0]  RST_CTRL     = 8'h00;
  localparam logic [15:0] RST_WDOG_PER = 16'hffff;

  typedef struct packed {
    logic [2:0] unlock_exp;
    logic [4:0] lock_exp;
  } lock_cfg_s;

  localparam lock_cfg_s RST_LOCK_CFG = '{unlock_exp: 3'h0, lock_exp: 5'h00};

endpackage : loop_lock_pkg

// ==== src/loop_lock_and_ref_monitor.sv ====
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

// ============================================================
// Lock qualifier with hysteresis
module lock_qualifier (
  input  wire logic                   core_clk_in,  // System clock
  input  wire logic                   resetn_in,    // Async reset, low
  input  wire logic                   ce_in,        // Clock enable
  input  wire logic                   strobe_in,    // Divider strobe
  input  wire logic                   match_in,     // Comparator result
  input  wire loop_lock_pkg::lock_cfg_s cfg_in,     // Exponents
  output logic                        lock_out      // Lock indication
);
  import loop_lock_pkg::*;

  typedef enum logic [1:0] {SEEK = 2'b01, LOCKED = 2'b10} lock_state_e;

  lock_state_e state, next_state;
  logic [20:0] cnt, next_cnt;
  logic [20:0] lock_goal;
  logic [20:0] unlock_goal;
  logic [4:0]  lock_exp;

  // Out-of-range exponents are clamped rather than left to wrap
  assign lock_exp    = (cfg_in.lock_exp > LOCK_EXP_MAX) ? LOCK_EXP_MAX : cfg_in.lock_exp;
  assign lock_goal   = 21'h000001 << lock_exp;
  assign unlock_goal = 21'h000002 << cfg_in.unlock_exp;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (strobe_in) begin
      unique case (state)
        SEEK: begin
          if (!match_in) begin
            next_cnt = '0;
          end else if (cnt + 21'h1 >= lock_goal) begin
            next_state = LOCKED;
            next_cnt   = '0;
          end else begin
            next_cnt = cnt + 21'h1;
          end
        end
        LOCKED: begin
          if (match_in) begin
            next_cnt = '0;
          end else if (cnt + 21'h1 >= unlock_goal) begin
            next_state = SEEK;
            next_cnt   = '0;
          end else begin
            next_cnt = cnt + 21'h1;
          end
        end
        default: begin
          next_state = SEEK;
          next_cnt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= SEEK;
      cnt   <= '0;
    end else if (ce_in) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign lock_out = (state == LOCKED);

endmodule : lock_qualifier

// ============================================================
// Reference loss watchdog
module ref_watchdog #(
  parameter int PERIOD_W = 16
) (
  input  wire logic                core_clk_in,  // System clock
  input  wire logic                resetn_in,    // Async reset, low
  input  wire logic                ce_in,        // Clock enable
  input  wire logic                ref_in,       // Raw reference pin
  input  wire logic                enable_in,    // Detector enable
  input  wire logic [PERIOD_W-1:0] period_in,    // Watchdog count
  output logic                     loss_out      // Loss of reference
);
  logic                sync1, sync2, sync3;
  logic                half, next_half;
  logic [PERIOD_W-1:0] cnt, next_cnt;
  logic                loss, next_loss;
  logic                ref_rise;

  // Pin crosses into the clock domain; sync3 only feeds the edge detect
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (ce_in) begin
      sync1 <= ref_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign ref_rise = sync2 & ~sync3;

  always_comb begin
    next_half = ~half;
    next_cnt  = cnt;
    next_loss = loss;
    if (!enable_in) begin
      next_cnt  = '0;
      next_loss = 1'b0;
    end else if (ref_rise) begin
      next_cnt  = '0;
      next_loss = 1'b0;
    end else if (cnt >= period_in) begin
      next_loss = 1'b1;
    end else if (half) begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half <= 1'b0;
      cnt  <= '0;
      loss <= 1'b0;
    end else if (ce_in) begin
      half <= next_half;
      cnt  <= next_cnt;
      loss <= next_loss;
    end
  end

  assign loss_out = loss;

endmodule : ref_watchdog

// ============================================================
// Top: offset adder, lock detectors, loss monitors, registers
module loop_lock_and_ref_monitor #(
  parameter int SAMPLE_W = 32,
  parameter int OFFSET_W = 14,
  parameter int PERIOD_W = 16,
  parameter int PINS     = 4
) (
  input  wire logic                core_clk_in,         // 125 MHz clock
  input  wire logic                resetn_in,           // Async reset, low
  input  wire logic                ce_in,               // Clock enable
  input  wire logic [7:0]          avs_address_in,      // Byte address
  input  wire logic                avs_read_in,         // Read request
  input  wire logic                avs_write_in,        // Write request
  input  wire logic [31:0]         avs_writedata_in,    // Write data
  input  wire logic [3:0]          avs_byteenable_in,   // Byte lanes
  output logic [31:0]              avs_readdata_out,    // Read data
  output logic                     avs_waitrequest_out, // Stall
  input  wire logic [SAMPLE_W-1:0] sample_in,           // Detector sample
  input  wire logic                sample_valid_in,     // Divider strobe
  output logic [SAMPLE_W-1:0]      loop_sample_out,     // Offset sample
  output logic                     loop_valid_out,      // Sample strobe
  input  wire logic                reference_input_a,   // Reference A pin
  input  wire logic                reference_input_b,   // Reference B pin
  output logic                     phase_lock_out,      // Phase locked
  output logic                     freq_lock_out,       // Frequency locked
  output logic [PINS-1:0]          multi_purpose_status_pins_out // Status pins
);
  import loop_lock_pkg::*;

  // ==========================================================
  // Register file
  logic [OFFSET_W-1:0] phase_offset_constant, next_phase_offset_constant;
  logic [31:0]         phase_lock_threshold, next_phase_lock_threshold;
  logic [31:0]         freq_lock_threshold, next_freq_lock_threshold;
  lock_cfg_s           phase_cfg, next_phase_cfg;
  lock_cfg_s           freq_cfg, next_freq_cfg;
  logic [7:0]          ref_ctrl, next_ref_ctrl;
  logic [PERIOD_W-1:0] period_a, next_period_a;
  logic [PERIOD_W-1:0] period_b, next_period_b;
  logic [1:0]          irq_req, next_irq_req;
  logic [1:0]          loss_q, next_loss_q;
  logic [PINS-1:0]     pins, next_pins;
  logic                ack, next_ack;
  logic [31:0]         rdata, next_rdata;
  logic [1:0]          reference_loss_flag;
  logic [1:0]          loss_rise;
  logic [31:0]         wmask;
  logic [31:0]         rd_mux;
  logic                wr_go;

  assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // One wait state per access keeps the read mux off the bus timing path
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign wr_go               = avs_write_in & ack;
  assign loss_rise           = reference_loss_flag & ~loss_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in & 8'hfc)
      OFS_PHASE_OFFSET: rd_mux = 32'(phase_offset_constant);
      OFS_PHASE_THR:    rd_mux = phase_lock_threshold;
      OFS_FREQ_THR:     rd_mux = freq_lock_threshold;
      OFS_PHASE_WDOG:   rd_mux = {21'h0, phase_cfg.unlock_exp, 3'h0, phase_cfg.lock_exp};
      OFS_FREQ_WDOG:    rd_mux = {21'h0, freq_cfg.unlock_exp, 3'h0, freq_cfg.lock_exp};
      OFS_REF_CTRL:     rd_mux = 32'(ref_ctrl);
      OFS_WDOG_PER_A:   rd_mux = 32'(period_a);
      OFS_WDOG_PER_B:   rd_mux = 32'(period_b);
      OFS_STATUS:       rd_mux = {28'h0, reference_loss_flag, freq_lock_out, phase_lock_out};
      OFS_IRQ_REQ:      rd_mux = 32'(irq_req);
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic [31:0] w;
    w = 32'h0000_0000;
    next_ack                   = (avs_read_in | avs_write_in) & ~ack;
    next_rdata                 = (avs_read_in & ~ack) ? rd_mux : rdata;
    next_phase_offset_constant = phase_offset_constant;
    next_phase_lock_threshold  = phase_lock_threshold;
    next_freq_lock_threshold   = freq_lock_threshold;
    next_phase_cfg             = phase_cfg;
    next_freq_cfg              = freq_cfg;
    next_ref_ctrl              = ref_ctrl;
    next_period_a              = period_a;
    next_period_b              = period_b;
    next_irq_req               = irq_req;
    next_loss_q                = reference_loss_flag;
    if (wr_go) begin
      unique case (avs_address_in & 8'hfc)
        OFS_PHASE_OFFSET: begin
          w = merge(32'(phase_offset_constant), avs_writedata_in, wmask);
          next_phase_offset_constant = w[OFFSET_W-1:0];
        end
        OFS_PHASE_THR: next_phase_lock_threshold =
          merge(phase_lock_threshold, avs_writedata_in, wmask);
        OFS_FREQ_THR: next_freq_lock_threshold =
          merge(freq_lock_threshold, avs_writedata_in, wmask);
        OFS_PHASE_WDOG: begin
          w = merge({21'h0, phase_cfg.unlock_exp, 3'h0, phase_cfg.lock_exp},
                    avs_writedata_in, wmask);
          next_phase_cfg.lock_exp   = w[LOCK_EXP_LSB+:5];
          next_phase_cfg.unlock_exp = w[UNLOCK_EXP_LSB+:3];
        end
        OFS_FREQ_WDOG: begin
          w = merge({21'h0, freq_cfg.unlock_exp, 3'h0, freq_cfg.lock_exp},
                    avs_writedata_in, wmask);
          next_freq_cfg.lock_exp   = w[LOCK_EXP_LSB+:5];
          next_freq_cfg.unlock_exp = w[UNLOCK_EXP_LSB+:3];
        end
        OFS_REF_CTRL: if (avs_byteenable_in[0]) next_ref_ctrl = avs_writedata_in[7:0];
        OFS_WDOG_PER_A: begin
          w = merge(32'(period_a), avs_writedata_in, wmask);
          next_period_a = w[PERIOD_W-1:0];
        end
        OFS_WDOG_PER_B: begin
          w = merge(32'(period_b), avs_writedata_in, wmask);
          next_period_b = w[PERIOD_W-1:0];
        end
        OFS_IRQ_REQ: if (avs_byteenable_in[0]) next_irq_req = irq_req & ~avs_writedata_in[1:0];
        default: ;
      endcase
    end
    // A new loss beats a clear landing in the same cycle
    next_irq_req = next_irq_req | loss_rise;
  end

  always_comb begin
    next_pins = '0;
    for (int k = 0; k < PINS; k++) begin
      if (ref_ctrl[CTL_ROUTE_A] && 32'(ref_ctrl[CTL_PIN_A_LSB+:2]) == k)
        next_pins[k] = next_pins[k] | reference_loss_flag[0];
      if (ref_ctrl[CTL_ROUTE_B] && 32'(ref_ctrl[CTL_PIN_B_LSB+:2]) == k)
        next_pins[k] = next_pins[k] | reference_loss_flag[1];
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_offset_constant <= RST_OFFSET;
      phase_lock_threshold  <= RST_THR;
      freq_lock_threshold   <= RST_THR;
      phase_cfg             <= RST_LOCK_CFG;
      freq_cfg              <= RST_LOCK_CFG;
      ref_ctrl              <= RST_CTRL;
      period_a              <= RST_WDOG_PER;
      period_b              <= RST_WDOG_PER;
      irq_req               <= 2'b00;
      loss_q                <= 2'b00;
      pins                  <= '0;
      ack                   <= 1'b0;
      rdata                 <= 32'h0000_0000;
    end else if (ce_in) begin
      phase_offset_constant <= next_phase_offset_constant;
      phase_lock_threshold  <= next_phase_lock_threshold;
      freq_lock_threshold   <= next_freq_lock_threshold;
      phase_cfg             <= next_phase_cfg;
      freq_cfg              <= next_freq_cfg;
      ref_ctrl              <= next_ref_ctrl;
      period_a              <= next_period_a;
      period_b              <= next_period_b;
      irq_req               <= next_irq_req;
      loss_q                <= next_loss_q;
      pins                  <= next_pins;
      ack                   <= next_ack;
      rdata                 <= next_rdata;
    end
  end

  assign avs_readdata_out              = rdata;
  assign multi_purpose_status_pins_out = pins;

  // ==========================================================
  // Offset adder and comparators
  logic [SAMPLE_W-1:0] adj, next_adj;
  logic [SAMPLE_W-1:0] prev, next_prev;
  logic                adj_valid, next_adj_valid;
  logic                have_prev, next_have_prev;
  logic                diff_ok, next_diff_ok;
  logic [SAMPLE_W:0]   diff;
  logic [SAMPLE_W:0]   phase_mag;
  logic [SAMPLE_W:0]   freq_mag;
  logic                phase_match;
  logic                freq_match;

  always_comb begin
    next_adj       = adj;
    next_prev      = prev;
    next_have_prev = have_prev;
    next_diff_ok   = diff_ok;
    next_adj_valid = sample_valid_in;
    if (sample_valid_in) begin
      next_adj = sample_in + {{(SAMPLE_W-OFFSET_W){phase_offset_constant[OFFSET_W-1]}},
                              phase_offset_constant};
      next_prev      = adj;
      next_diff_ok   = have_prev;
      next_have_prev = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      adj       <= '0;
      prev      <= '0;
      adj_valid <= 1'b0;
      have_prev <= 1'b0;
      diff_ok   <= 1'b0;
    end else if (ce_in) begin
      adj       <= next_adj;
      prev      <= next_prev;
      adj_valid <= next_adj_valid;
      have_prev <= next_have_prev;
      diff_ok   <= next_diff_ok;
    end
  end

  assign loop_sample_out = adj;
  assign loop_valid_out  = adj_valid;

  // Difference is one bit wider so a full-scale swing cannot wrap
  assign diff      = {adj[SAMPLE_W-1], adj} - {prev[SAMPLE_W-1], prev};
  // Negating the sign-extended word keeps the most negative sample's magnitude positive
  assign phase_mag = adj[SAMPLE_W-1] ? -{1'b1, adj}
                                     : (SAMPLE_W+1)'(adj);
  assign freq_mag  = diff[SAMPLE_W] ? -diff : diff;
  assign phase_match = phase_mag <= (SAMPLE_W+1)'(phase_lock_threshold);
  // The first sample after reset has no predecessor and never matches
  assign freq_match  = diff_ok && (freq_mag <= (SAMPLE_W+1)'(freq_lock_threshold));

  // ==========================================================
  // Lock qualifiers and reference watchdogs
  lock_qualifier u_phase_lock (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .strobe_in   (adj_valid),
    .match_in    (phase_match),
    .cfg_in      (phase_cfg),
    .lock_out    (phase_lock_out)
  );

  lock_qualifier u_freq_lock (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .strobe_in   (adj_valid),
    .match_in    (freq_match),
    .cfg_in      (freq_cfg),
    .lock_out    (freq_lock_out)
  );

  ref_watchdog #(.PERIOD_W(PERIOD_W)) u_wdog_a (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .ref_in      (reference_input_a),
    .enable_in   (ref_ctrl[CTL_EN_A]),
    .period_in   (period_a),
    .loss_out    (reference_loss_flag[0])
  );

  ref_watchdog #(.PERIOD_W(PERIOD_W)) u_wdog_b (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .ref_in      (reference_input_b),
    .enable_in   (ref_ctrl[CTL_EN_B]),
    .period_in   (period_b),
    .loss_out    (reference_loss_flag[1])
  );

endmodule : loop_lock_and_ref_monitor

// ==== tb/loop_lock_sva.sv ====
`timescale 1ns/1ps
// ==========
// Port checker
module loop_lock_sva (
  input wire logic        core_clk_in,                  // Clock
  input wire logic        resetn_in,                    // Reset
  input wire logic        ce_in,                        // Enable
  input wire logic [7:0]  avs_address_in,               // Address
  input wire logic        avs_read_in,                  // Read
  input wire logic        avs_write_in,                 // Write
  input wire logic [31:0] avs_writedata_in,             // Wdata
  input wire logic        avs_waitrequest_out,          // Stall
  input wire logic [31:0] sample_in,                    // Sample
  input wire logic        sample_valid_in,              // Strobe
  input wire logic [31:0] loop_sample_out,              // Sum
  input wire logic        loop_valid_out,               // Sum strobe
  input wire logic        reference_input_a,            // Ref A
  input wire logic        reference_input_b,            // Ref B
  input wire logic        phase_lock_out,               // Phase lock
  input wire logic        freq_lock_out,                // Freq lock
  input wire logic [3:0]  multi_purpose_status_pins_out // Pins
);
  logic [13:0] ofs;
  logic [7:0]  age_a, age_b, nstb, tot;
  logic        ra_q, rb_q, pl_q;
  wire  [31:0] sofs = {{18{ofs[13]}}, ofs};
  // Shadow of the offset and strobe/edge ages, kept from bus and pin traffic
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {ofs, age_a, age_b, nstb, tot, ra_q, rb_q, pl_q} <= '0;
    end else begin
      if (avs_write_in && !avs_waitrequest_out && avs_address_in[7:2] == 6'h00) begin
        ofs <= avs_writedata_in[13:0];
      end
      ra_q  <= reference_input_a;
      rb_q  <= reference_input_b;
      pl_q  <= phase_lock_out;
      age_a <= (reference_input_a && !ra_q) ? 8'h00 : age_a + {7'h0, age_a != 8'hff};
      age_b <= (reference_input_b && !rb_q) ? 8'h00 : age_b + {7'h0, age_b != 8'hff};
      nstb  <= (phase_lock_out && !pl_q) ? 8'h00 :
               nstb + {7'h0, loop_valid_out && nstb != 8'hff};
      tot   <= tot + {7'h0, loop_valid_out && tot != 8'hff};
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  strobe_pass_a: assert property (
    sample_valid_in && ce_in |=> loop_valid_out) else $error("strobe lost");
  offset_sum_a: assert property (
    loop_valid_out |-> loop_sample_out == $past(sample_in) + $past(sofs))
    else $error("offset sum wrong");
  bus_stall_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out)
    else $error("stall too long");
  bus_idle_a: assert property (
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out) else $error("idle stall");
  lock_on_strobe_a: assert property (
    $rose(phase_lock_out) |-> $past(loop_valid_out) || $past(loop_valid_out, 2))
    else $error("lock without strobe");
  unlock_hyst_a: assert property (
    $fell(phase_lock_out) |-> nstb >= 8'd2) else $error("unlock too early");
  freq_first_a: assert property (
    $rose(freq_lock_out) |-> tot >= 8'd2) else $error("freq lock too early");
  loss_quiet_a: assert property (
    $rose(|multi_purpose_status_pins_out) |-> age_a >= 8'd6 || age_b >= 8'd6)
    else $error("loss while reference active");
  cover property ($rose(phase_lock_out));
  cover property ($fell(phase_lock_out));
  cover property ($rose(|multi_purpose_status_pins_out));
endmodule : loop_lock_sva

// ==== tb/sample_ref_source.sv ====
`timescale 1ns/1ps
// ==========
// Far side: sample stream on a six-cycle divider cadence, two references
module sample_ref_source (
  input  wire logic        core_clk_in, // Clock
  input  wire logic        resetn_in,   // Reset
  input  wire logic        run_in,      // Stream on
  input  wire logic [31:0] value_in,    // Sample value
  input  wire logic [3:0]  half_a_in,   // Ref A half period, 0 stops
  input  wire logic [3:0]  half_b_in,   // Ref B half period, 0 stops
  output logic      [31:0] sample_out,  // Sample
  output logic             valid_out,   // Strobe
  output logic             ref_a_out,   // Ref A
  output logic             ref_b_out    // Ref B
);
  logic [2:0] div;
  logic [3:0] cnt_a, cnt_b;
  // Stopped references sit low like a lost clock; data between strobes is junk
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {div, cnt_a, cnt_b, valid_out, ref_a_out, ref_b_out} <= '0;
      sample_out <= 32'h0;
    end else begin
      div        <= (div == 3'h5) ? 3'h0 : div + 3'h1;
      valid_out  <= run_in && div == 3'h0;
      sample_out <= (run_in && div == 3'h0) ? value_in : ~sample_out;
      cnt_a      <= (half_a_in == 4'h0 || cnt_a + 4'h1 >= half_a_in) ? 4'h0 : cnt_a + 4'h1;
      cnt_b      <= (half_b_in == 4'h0 || cnt_b + 4'h1 >= half_b_in) ? 4'h0 : cnt_b + 4'h1;
      ref_a_out  <= (half_a_in != 4'h0) && (ref_a_out ^ (cnt_a + 4'h1 >= half_a_in));
      ref_b_out  <= (half_b_in != 4'h0) && (ref_b_out ^ (cnt_b + 4'h1 >= half_b_in));
    end
  end
endmodule : sample_ref_source

// ==== tb/test_loop_lock_and_ref_monitor.sv ====
`timescale 1ns/1ps
// ==========
// Bench top
module test_loop_lock_and_ref_monitor;
  import loop_lock_pkg::*;
  logic        core_clk_in       = 1'b0;
  logic        resetn_in         = 1'b0;
  logic        ce_in             = 1'b1;
  logic        avs_read_in       = 1'b0;
  logic        avs_write_in      = 1'b0;
  logic        run               = 1'b0;
  logic [7:0]  avs_address_in    = 8'h00;
  logic [31:0] avs_writedata_in  = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] value             = 32'h0;
  logic [3:0]  half_a            = 4'h0;
  logic [31:0] avs_readdata_out, sample_in, loop_sample_out;
  logic        avs_waitrequest_out, sample_valid_in, loop_valid_out, phase_lock_out;
  logic        reference_input_a, reference_input_b, freq_lock_out;
  logic [3:0]  multi_purpose_status_pins_out;
  int          num_errors        = 0;
  int          cmp_count         = 0;
  always #4 core_clk_in = ~core_clk_in;
  loop_lock_and_ref_monitor DUT (.core_clk_in, .resetn_in, .ce_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .sample_in, .sample_valid_in, .loop_sample_out, .loop_valid_out,
    .reference_input_a, .reference_input_b, .phase_lock_out, .freq_lock_out,
    .multi_purpose_status_pins_out);
  sample_ref_source model (.core_clk_in, .resetn_in, .run_in(run), .value_in(value),
    .half_a_in(half_a), .half_b_in(half_a), .sample_out(sample_in), .valid_out(sample_valid_in),
    .ref_a_out(reference_input_a), .ref_b_out(reference_input_b));
  // ==========
  // Shared tasks
  task automatic wrap_up;
    $display("compares=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic fail;
    num_errors++;
    wrap_up();
  endtask : fail
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    if (n >= 50) fail();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd
  // Wait for k forwarded strobes, then let the lock state settle
  task automatic strobes(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge core_clk_in);
        n++;
      end while (loop_valid_out !== 1'b1 && n < 100);
      if (n >= 100) fail();
    end
    repeat (2) @(posedge core_clk_in);
  endtask : strobes
  task automatic do_reset;
    resetn_in <= 1'b0;
    run       <= 1'b0;
    half_a    <= 4'h0;
    repeat (20) @(posedge core_clk_in);
    resetn_in <= 1'b1;
  endtask : do_reset
  // ==========
  // Scenarios
  task automatic t_regs;
    rd(OFS_WDOG_PER_A, 32'h0000ffff);
    rd(OFS_WDOG_PER_B, 32'h0000ffff);
    rd(OFS_REF_CTRL, 32'h0);
    wr(8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    rd(OFS_IRQ_REQ, 32'h0);
    rd(OFS_STATUS, 32'h0);
  endtask : t_regs
  task automatic t_offset;
    wr(OFS_PHASE_OFFSET, 32'h00003801);
    rd(OFS_PHASE_OFFSET, 32'h00003801);
    value <= 32'h00001000;
    run   <= 1'b1;
    strobes(1);
    check(loop_sample_out, 32'h00000801);
    wr(OFS_PHASE_OFFSET, 32'h000007ff);
    strobes(2);
    check(loop_sample_out, 32'h000017ff);
  endtask : t_offset
  task automatic t_phase;
    do_reset();
    wr(OFS_PHASE_THR, 32'd100);
    wr(OFS_PHASE_WDOG, 32'h00000002);
    value <= 32'hffffff9c;
    run   <= 1'b1;
    strobes(3);
    check(32'(phase_lock_out), 32'h0);
    strobes(1);
    check(32'(phase_lock_out), 32'h1);
    value <= 32'h00000065;
    strobes(1);
    check(32'(phase_lock_out), 32'h1);
    strobes(1);
    check(32'(phase_lock_out), 32'h0);
    value <= 32'hffffff9c;
    strobes(4);
    check(32'(phase_lock_out), 32'h1);
  endtask : t_phase
  task automatic t_freq;
    do_reset();
    wr(OFS_FREQ_THR, 32'd10);
    wr(OFS_FREQ_WDOG, 32'h00000101);
    value <= 32'd500;
    run   <= 1'b1;
    strobes(2);
    check(32'(freq_lock_out), 32'h0);
    strobes(1);
    check(32'(freq_lock_out), 32'h1);
    check(32'(phase_lock_out), 32'h0);
  endtask : t_freq
  task automatic t_loss;
    do_reset();
    half_a <= 4'd3;
    wr(OFS_WDOG_PER_A, 32'd5);
    wr(OFS_WDOG_PER_B, 32'd5);
    wr(OFS_REF_CTRL, 32'h000000ef);
    repeat (60) @(posedge core_clk_in);
    check(32'(multi_purpose_status_pins_out), 32'h0);
    half_a <= 4'h0;
    repeat (40) @(posedge core_clk_in);
    check(32'(multi_purpose_status_pins_out), 32'hc);
    rd(OFS_STATUS, 32'hc);
    rd(OFS_IRQ_REQ, 32'h3);
    wr(OFS_IRQ_REQ, 32'h1);
    rd(OFS_IRQ_REQ, 32'h2);
    half_a <= 4'd3;
    repeat (40) @(posedge core_clk_in);
    check(32'(multi_purpose_status_pins_out), 32'h0);
  endtask : t_loss
  initial begin
    do_reset();
    t_regs();
    t_offset();
    t_phase();
    t_freq();
    t_loss();
    wrap_up();
  end
endmodule : test_loop_lock_and_ref_monitor

bind loop_lock_and_ref_monitor loop_lock_sva chk (.core_clk_in, .resetn_in, .ce_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out,
  .sample_in, .sample_valid_in, .loop_sample_out, .loop_valid_out, .reference_input_a,
  .reference_input_b, .phase_lock_out, .freq_lock_out, .multi_purpose_status_pins_out);
